// ---- inc/cdf_pkg.sv ----
// card descriptor field constants, field positions and carrier types
package cdf_pkg;

  // bus register byte offsets
  localparam logic [7:0] OFS_DESC0  = 8'h00;
  localparam logic [7:0] OFS_DESC1  = 8'h04;
  localparam logic [7:0] OFS_DESC2  = 8'h08;
  localparam logic [7:0] OFS_DESC3  = 8'h0C;
  localparam logic [7:0] OFS_PROG   = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // fixed descriptor field values
  localparam logic [1:0]  VAL_STRUCTURE    = 2'h1;
  localparam logic [3:0]  VAL_SPEC         = 4'h2;
  localparam logic [7:0]  VAL_ACCESS_TIME  = 8'h0E;
  localparam logic [7:0]  VAL_ACCESS_CLKS  = 8'h01;
  localparam logic [7:0]  VAL_XFER_SPEED   = 8'h2A;
  localparam logic [11:0] VAL_CMD_CLASSES  = 12'h0FF;
  localparam logic [3:0]  VAL_READ_EXP     = 4'h9;
  localparam logic        VAL_READ_PART    = 1'h1;
  localparam logic        VAL_DRV_STAGE    = 1'h0;
  localparam logic [11:0] VAL_CAP_BASE     = 12'h7A7;
  localparam logic [2:0]  VAL_CUR_LOW      = 3'h5;
  localparam logic [2:0]  VAL_CUR_HIGH     = 3'h4;
  localparam logic [2:0]  VAL_CAP_SHIFT    = 3'h3;
  localparam logic [4:0]  VAL_ERASE_UNIT   = 5'h00;
  localparam logic [4:0]  VAL_ERASE_CLUST  = 5'h0F;
  localparam logic [4:0]  VAL_PROT_CLUST   = 5'h01;
  localparam logic        VAL_PROT_ALLOW   = 1'h1;
  localparam logic [1:0]  VAL_PREF_CORR    = 2'h0;
  localparam logic [2:0]  VAL_PROG_RATIO   = 3'h2;
  localparam logic [3:0]  VAL_WRITE_EXP    = 4'h9;
  localparam logic        VAL_WRITE_PART   = 1'h0;

  // checksum generator taps below x^7, limits of encodings
  localparam logic [6:0]  CRC_POLY         = 7'h09;
  localparam logic [3:0]  MAX_LEN_EXP      = 4'hB;
  localparam logic [3:0]  MAX_SHIFT        = 4'h7;

  // programmable field positions in the program register
  localparam int PRG_COPY  = 0;
  localparam int PRG_PERM  = 1;
  localparam int PRG_TMP   = 2;
  localparam int PRG_FFAM  = 3;
  localparam int PRG_FCODE = 4;
  localparam int PRG_CORR  = 8;
  localparam int PRG_CRC   = 16;

  // status register positions
  localparam int STS_CRC   = 0;
  localparam int STS_MATCH = 8;
  localparam int STS_LOCK  = 9;
  localparam int STS_REFD  = 10;

  // block length port width
  localparam int LEN_W = 12;

  typedef struct packed {
    logic       copy;
    logic       perm_lock;
    logic       tmp_lock;
    logic       format_family;
    logic [1:0] format_code;
    logic [1:0] corr_scheme;
    logic [6:0] crc;
  } cdf_prog_t;

  typedef struct packed {
    logic             valid;
    logic             write;
    logic             erase;
    logic [LEN_W-1:0] len;
  } cdf_cmd_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } cdf_bus_t;

  typedef struct packed {
    cdf_bus_t     bus;
    logic [31:0]  rdata;
    cdf_prog_t    prog;
    logic [127:0] desc;
    logic [6:0]   calc_crc;
    logic         accept;
    logic         refuse;
    logic         refused_any;
  } cdf_state_t;

endpackage

// ---- logic/cdf_card_descriptor.sv ----
// card descriptor field bank with wishbone register access
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Function
// RULE1: driver stage present field reads 0, drivers not configurable.
// RULE2: capacity is (base+1) times 2^(shift+2) times 2^read exponent.
// RULE3: capacity base field is fixed at 0x7A7.
// RULE4: read and write current codes at low supply are fixed at 5.
// RULE5: read and write current codes at high supply are fixed at 4.
// RULE6: capacity shift is fixed at 3, multiplier 32.
// RULE7: erase unit field reads 0, one 512 byte write block.
// RULE8: erase cluster field reads 15, an 8 kByte group.
// RULE9: protect cluster count reads 1, a 16 kByte group.
// RULE10: protect cluster allowed flag reads 1.
// RULE11: preferred correction field reads 0.
// RULE12: program time ratio field reads 2.
// RULE13: write length exponent is fixed at 9, 512 bytes.
// RULE14: partial writes not allowed; only full write block length accepted.
// RULE15: permanent lock, programmable once, refuses all writes and erases.
// RULE16: temporary lock, reprogrammable, refuses writes and erases while set.
// RULE17: duplicate flag 0 original, 1 copy, programmable only once.
// RULE18: format family 0 codes partitioned, boot sector, universal, others.
// RULE19: correction scheme 0 none, 1 three-bit BCH, rest reserved.
// RULE20: checksum is remainder of bits 127..8 times x^7 by x^7+x^3+1.
// RULE21: host writes a fresh checksum after defining new content.
// RULE22: fields read fixed values except duplicate, locks, format, correction, checksum.
module cdf_card_descriptor #(
  parameter logic [3:0] WRITE_EXP = cdf_pkg::VAL_WRITE_EXP,
  parameter logic [2:0] CAP_SHIFT = cdf_pkg::VAL_CAP_SHIFT
) (
  input  wire logic                core_clk,
  input  wire logic                nrst,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic                     wb_ack_o,
  output logic [31:0]              wb_dat_o,
  input  wire cdf_pkg::cdf_cmd_t   cmd_i,
  output logic                     cmd_accept_o,
  output logic                     cmd_refuse_o,
  output logic [127:0]             card_descriptor_o
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (WRITE_EXP > cdf_pkg::MAX_LEN_EXP) begin : g_bad_exp
    $error("write length exponent out of range");
  end
  if ({1'b0, CAP_SHIFT} > cdf_pkg::MAX_SHIFT) begin : g_bad_shift
    $error("capacity shift out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // remainder of the 120 message bits times x^7 by the generator
  function automatic logic [6:0] cdf_crc7(input logic [119:0] msg);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      fb = msg[i] ^ c[6];
      c  = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ cdf_pkg::CRC_POLY;
      end
    end
    return c;
  endfunction

  // assemble the 128-bit descriptor from fixed and programmed fields
  function automatic logic [127:0] cdf_build(input cdf_pkg::cdf_prog_t p);
    logic [127:0] d;
    d = 128'h0;
    d[127:126] = cdf_pkg::VAL_STRUCTURE;
    d[125:122] = cdf_pkg::VAL_SPEC;
    d[119:112] = cdf_pkg::VAL_ACCESS_TIME;
    d[111:104] = cdf_pkg::VAL_ACCESS_CLKS;
    d[103:96]  = cdf_pkg::VAL_XFER_SPEED;
    d[95:84]   = cdf_pkg::VAL_CMD_CLASSES;
    // RULE2: read length exponent, capacity term
    d[83:80]   = cdf_pkg::VAL_READ_EXP;
    d[79]      = cdf_pkg::VAL_READ_PART;
    // RULE1: no driver stage
    d[76]      = cdf_pkg::VAL_DRV_STAGE;
    // RULE3: capacity base
    d[73:62]   = cdf_pkg::VAL_CAP_BASE;
    // RULE4: low supply current codes
    d[61:59]   = cdf_pkg::VAL_CUR_LOW;
    d[55:53]   = cdf_pkg::VAL_CUR_LOW;
    // RULE5: high supply current codes
    d[58:56]   = cdf_pkg::VAL_CUR_HIGH;
    d[52:50]   = cdf_pkg::VAL_CUR_HIGH;
    // RULE6: capacity shift
    d[49:47]   = CAP_SHIFT;
    // RULE7: erase unit
    d[46:42]   = cdf_pkg::VAL_ERASE_UNIT;
    // RULE8: erase cluster
    d[41:37]   = cdf_pkg::VAL_ERASE_CLUST;
    // RULE9: protect cluster count
    d[36:32]   = cdf_pkg::VAL_PROT_CLUST;
    // RULE10: protect cluster allowed
    d[31]      = cdf_pkg::VAL_PROT_ALLOW;
    // RULE11: preferred correction
    d[30:29]   = cdf_pkg::VAL_PREF_CORR;
    // RULE12: program time ratio
    d[28:26]   = cdf_pkg::VAL_PROG_RATIO;
    // RULE13: write length exponent
    d[25:22]   = WRITE_EXP;
    // RULE14: partial write flag
    d[21]      = cdf_pkg::VAL_WRITE_PART;
    // RULE22: programmed fields read back
    d[15]      = p.format_family;
    d[14]      = p.copy;
    d[13]      = p.perm_lock;
    d[12]      = p.tmp_lock;
    d[11:10]   = p.format_code;
    d[9:8]     = p.corr_scheme;
    d[7:1]     = p.crc;
    d[0]       = 1'b1;
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  cdf_pkg::cdf_state_t state_r;
  cdf_pkg::cdf_state_t state_nxt;
  logic                req;
  logic                locked;
  localparam int LENW_T = cdf_pkg::LEN_W;
  logic [LENW_T-1:0]   full_len;

  assign req      = wb_cyc_i & wb_stb_i;
  assign locked   = state_r.prog.perm_lock | state_r.prog.tmp_lock;
  assign full_len = LENW_T'(1) << WRITE_EXP;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    cdf_pkg::cdf_prog_t np;
    logic [31:0]        rd;
    state_nxt        = state_r;
    np               = state_r.prog;
    rd               = 32'h0000_0000;
    state_nxt.accept = 1'b0;
    state_nxt.refuse = 1'b0;

    // bus slave, one ack per request
    case (state_r.bus)
      cdf_pkg::BUS_IDLE: begin
        if (req) begin
          state_nxt.bus = cdf_pkg::BUS_ACK;
          case (wb_adr_i)
            cdf_pkg::OFS_DESC0:  rd = state_r.desc[31:0];
            cdf_pkg::OFS_DESC1:  rd = state_r.desc[63:32];
            cdf_pkg::OFS_DESC2:  rd = state_r.desc[95:64];
            cdf_pkg::OFS_DESC3:  rd = state_r.desc[127:96];
            cdf_pkg::OFS_PROG: begin
              rd[cdf_pkg::PRG_COPY]                       = state_r.prog.copy;
              rd[cdf_pkg::PRG_PERM]                       = state_r.prog.perm_lock;
              rd[cdf_pkg::PRG_TMP]                        = state_r.prog.tmp_lock;
              rd[cdf_pkg::PRG_FFAM]                       = state_r.prog.format_family;
              rd[cdf_pkg::PRG_FCODE+1:cdf_pkg::PRG_FCODE] = state_r.prog.format_code;
              rd[cdf_pkg::PRG_CORR+1:cdf_pkg::PRG_CORR]   = state_r.prog.corr_scheme;
              rd[cdf_pkg::PRG_CRC+6:cdf_pkg::PRG_CRC]     = state_r.prog.crc;
            end
            cdf_pkg::OFS_STATUS: begin
              rd[cdf_pkg::STS_CRC+6:cdf_pkg::STS_CRC] = state_r.calc_crc;
              rd[cdf_pkg::STS_MATCH] = (state_r.calc_crc == state_r.prog.crc);
              rd[cdf_pkg::STS_LOCK]  = locked;
              rd[cdf_pkg::STS_REFD]  = state_r.refused_any;
            end
            default: rd = 32'h0000_0000;
          endcase
          state_nxt.rdata = rd;
          if (wb_we_i && wb_adr_i == cdf_pkg::OFS_PROG && wb_sel_i[0]) begin
            // RULE17: duplicate flag set once, never cleared
            np.copy          = state_r.prog.copy | wb_dat_i[cdf_pkg::PRG_COPY];
            // RULE15: permanent lock set once, never cleared
            np.perm_lock     = state_r.prog.perm_lock | wb_dat_i[cdf_pkg::PRG_PERM];
            // RULE16: temporary lock freely reprogrammed
            np.tmp_lock      = wb_dat_i[cdf_pkg::PRG_TMP];
            // RULE18: format family and code
            np.format_family = wb_dat_i[cdf_pkg::PRG_FFAM];
            np.format_code   = wb_dat_i[cdf_pkg::PRG_FCODE+1:cdf_pkg::PRG_FCODE];
          end
          if (wb_we_i && wb_adr_i == cdf_pkg::OFS_PROG && wb_sel_i[1]) begin
            // RULE19: correction scheme code
            np.corr_scheme   = wb_dat_i[cdf_pkg::PRG_CORR+1:cdf_pkg::PRG_CORR];
          end
          if (wb_we_i && wb_adr_i == cdf_pkg::OFS_PROG && wb_sel_i[2]) begin
            // RULE21: host supplies the checksum field
            np.crc           = wb_dat_i[cdf_pkg::PRG_CRC+6:cdf_pkg::PRG_CRC];
          end
          if (wb_we_i && wb_adr_i == cdf_pkg::OFS_STATUS && wb_sel_i[1]) begin
            if (wb_dat_i[cdf_pkg::STS_REFD]) begin
              state_nxt.refused_any = 1'b0;
            end
          end
        end
      end
      cdf_pkg::BUS_ACK: begin
        state_nxt.bus = cdf_pkg::BUS_IDLE;
      end
      default: begin
        state_nxt.bus = cdf_pkg::BUS_IDLE;
      end
    endcase
    state_nxt.prog = np;

    // RULE15: RULE16: RULE14: write and erase gating
    if (cmd_i.valid && (cmd_i.write || cmd_i.erase)) begin
      if (locked || (cmd_i.write && cmd_i.len != full_len)) begin
        state_nxt.refuse      = 1'b1;
        state_nxt.refused_any = 1'b1;
      end else begin
        state_nxt.accept      = 1'b1;
      end
    end else if (cmd_i.valid) begin
      state_nxt.accept = 1'b1;
    end

    // RULE22: descriptor image follows programmed fields
    state_nxt.desc     = cdf_build(state_r.prog);
    // RULE20: checksum over descriptor bits 127..8
    state_nxt.calc_crc = cdf_crc7(state_r.desc[127:8]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_r             <= '0;
      state_r.bus         <= cdf_pkg::BUS_IDLE;
      state_r.desc        <= cdf_build('0);
      state_r.calc_crc    <= 7'h00;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign wb_ack_o          = (state_r.bus == cdf_pkg::BUS_ACK);
  assign wb_dat_o          = state_r.rdata;
  assign cmd_accept_o      = state_r.accept;
  assign cmd_refuse_o      = state_r.refuse;
  assign card_descriptor_o = state_r.desc;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_write_req;
    cmd_i.valid && cmd_i.write;
  endsequence

  sequence s_erase_req;
    cmd_i.valid && cmd_i.erase;
  endsequence

  sequence s_prog_write;
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == cdf_pkg::OFS_PROG;
  endsequence

  a_drv_stage_zero: assert property (card_descriptor_o[76] == 1'b0) // RULE1
    else $error("driver stage field not zero");

  a_cap_base_fixed: assert property (card_descriptor_o[73:62] == 12'h7A7) // RULE3
    else $error("capacity base field wrong");

  a_cur_low_codes: assert property (card_descriptor_o[61:59] == 3'h5 // RULE4
                                    && card_descriptor_o[55:53] == 3'h5)
    else $error("low supply current code wrong");

  a_cur_high_codes: assert property (card_descriptor_o[58:56] == 3'h4 // RULE5
                                     && card_descriptor_o[52:50] == 3'h4)
    else $error("high supply current code wrong");

  a_write_exp_fixed: assert property (card_descriptor_o[25:22] == WRITE_EXP // RULE13
                                      && card_descriptor_o[21] == 1'b0)
    else $error("write length fields wrong");

  a_cap_shift_fixed: assert property (card_descriptor_o[49:47] == CAP_SHIFT) // RULE6
    else $error("capacity shift field wrong");

  a_read_exp_legal: assert property (card_descriptor_o[83:80] < 4'hC) // RULE2
    else $error("read length exponent out of range");

  a_erase_unit_zero: assert property (card_descriptor_o[46:42] == 5'h00) // RULE7
    else $error("erase unit field wrong");

  a_erase_cluster: assert property (card_descriptor_o[41:37] == 5'h0F) // RULE8
    else $error("erase cluster field wrong");

  a_protect_count: assert property (card_descriptor_o[36:32] == 5'h01) // RULE9
    else $error("protect cluster count wrong");

  a_protect_allowed: assert property (card_descriptor_o[31] == 1'b1) // RULE10
    else $error("protect cluster allowed flag wrong");

  a_pref_corr_zero: assert property (card_descriptor_o[30:29] == 2'h0) // RULE11
    else $error("preferred correction field wrong");

  a_prog_ratio_fixed: assert property (card_descriptor_o[28:26] == 3'h2) // RULE12
    else $error("program time ratio field wrong");

  a_full_write_ok: assert property (s_write_req ##0 cmd_i.len == full_len // RULE14
                                    ##0 !locked |=> cmd_accept_o && !cmd_refuse_o)
    else $error("full block write not accepted");

  a_answer_single: assert property (!(cmd_accept_o && cmd_refuse_o)) // RULE15
    else $error("command both accepted and refused");

  a_perm_refuses: assert property ((s_write_req or s_erase_req) ##0 // RULE15
                                   state_r.prog.perm_lock |=> cmd_refuse_o && !cmd_accept_o)
    else $error("write or erase passed permanent lock");

  a_tmp_refuses: assert property ((s_write_req or s_erase_req) ##0 // RULE16
                                  state_r.prog.tmp_lock |=> cmd_refuse_o)
    else $error("write or erase passed temporary lock");

  a_partial_refused: assert property (s_write_req ##0 cmd_i.len != full_len // RULE14
                                      |=> cmd_refuse_o)
    else $error("partial block write accepted");

  a_perm_sticky: assert property ($past(state_r.prog.perm_lock) |-> // RULE15
                                  state_r.prog.perm_lock)
    else $error("permanent lock cleared");

  a_copy_sticky: assert property (state_r.prog.copy |=> state_r.prog.copy) // RULE17
    else $error("duplicate flag cleared");

  a_prog_readback: assert property (s_prog_write ##0 wb_sel_i[0] // RULE22
                                    |-> ##3 card_descriptor_o[12] == $past(wb_dat_i[2], 3))
    else $error("temporary lock not reflected in descriptor");

  a_crc_tracks: assert property ($stable(card_descriptor_o)[*2] // RULE20
                                 |=> state_r.calc_crc == cdf_crc7($past(card_descriptor_o[127:8])))
    else $error("computed checksum does not follow descriptor");

endmodule

// ---- verif/cdf_host_model.sv ----
// host controller model: wishbone master, command source, checksum
`timescale 1ns/1ps
module cdf_host_model (
  input  wire logic             core_clk,
  output logic                  wb_cyc,
  output logic                  wb_stb,
  output logic                  wb_we,
  output logic [7:0]            wb_adr,
  output logic [3:0]            wb_sel,
  output logic [31:0]           wb_dat,
  input  wire logic             wb_ack,
  input  wire logic [31:0]      wb_rdat,
  output cdf_pkg::cdf_cmd_t     cmd,
  input  wire logic             accept,
  input  wire logic             refuse
);
  initial begin
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we  = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat = 32'h0;
    cmd    = '0;
  end
  // single classic cycle, released data shows the inverse
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 32'h0;
    @(posedge core_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_sel <= 4'hF;
    wb_dat <= wd;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (wb_ack === 1'b1) begin
        ok = 1'b1;
        rd = wb_rdat;
        break;
      end
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_dat <= ~wd;
  endtask
  task automatic send(input logic wr, input logic er, input logic [11:0] len,
                      output logic acc, output logic rfs);
    @(posedge core_clk);
    cmd <= cdf_pkg::cdf_cmd_t'{valid: 1'b1, write: wr, erase: er, len: len};
    @(posedge core_clk);
    cmd.valid <= 1'b0;
    @(posedge core_clk);
    acc = accept;
    rfs = refuse;
  endtask
  function automatic logic [6:0] crc7(input logic [119:0] m);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      fb = m[i] ^ c[6];
      c = {c[5:0], 1'b0};
      if (fb) c = c ^ 7'h09;
    end
    return c;
  endfunction
endmodule

// ---- verif/tb_card_descriptor_fields.sv ----
// self-checking bench for the card descriptor field bank
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_card_descriptor_fields;
  logic               core_clk;
  logic               nrst;
  logic               wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0]         wb_adr;
  logic [3:0]         wb_sel;
  logic [31:0]        wb_dat, wb_rdat;
  cdf_pkg::cdf_cmd_t  cmd;
  logic               accept, refuse;
  logic [127:0]       d;
  int                 failures;
  int                 n_tests;
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  cdf_card_descriptor dut (.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_ack_o(wb_ack), .wb_dat_o(wb_rdat), .cmd_i(cmd),
    .cmd_accept_o(accept), .cmd_refuse_o(refuse), .card_descriptor_o(d));
  cdf_host_model host (.core_clk(core_clk), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat(wb_dat),
    .wb_ack(wb_ack), .wb_rdat(wb_rdat), .cmd(cmd), .accept(accept), .refuse(refuse));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (failures == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    logic ok;
    host.bus(we, a, wd, rd, ok);
    if (ok !== 1'b1) begin
      failures++;
      $display("MISMATCH t=%0t bus timeout", $time);
      report_and_stop();
    end
  endtask
  // write program register, wait for descriptor and checksum to follow
  task automatic prog(input logic [31:0] v);
    logic [31:0] r;
    acc(1'b1, cdf_pkg::OFS_PROG, v, r);
    repeat (4) @(posedge core_clk);
  endtask
  task automatic cmd_chk(input logic wr, input logic er, input logic [11:0] len,
                         input logic ea);
    logic a, f;
    host.send(wr, er, len, a, f);
    `CHK({a, f}, {ea, ~ea})
  endtask
  function automatic logic [31:0] pv(input logic cp, input logic pm, input logic tp,
      input logic [1:0] code, input logic [1:0] corr, input logic [6:0] crc);
    return {9'h000, crc, 6'h00, corr, 2'h0, code, 1'b0, tp, pm, cp};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic [6:0]  c;
    longint      cap;
    nrst = 1'b0;
    failures = 0;
    n_tests = 0;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    `CHK(d[76], 1'b0)
    `CHK(d[73:62], 12'h7A7)
    `CHK({d[61:59], d[55:53]}, 6'h2D)
    `CHK({d[58:56], d[52:50]}, 6'h24)
    `CHK(d[49:47], 3'h3)
    `CHK(d[46:42], 5'h00)
    `CHK(d[41:37], 5'h0F)
    `CHK(d[36:32], 5'h01)
    `CHK(d[31], 1'b1)
    `CHK(d[30:29], 2'h0)
    `CHK(d[28:26], 3'h2)
    `CHK(d[25:22], 4'h9)
    `CHK(d[21], 1'b0)
    `CHK(d[15:0], 16'h0001)
    cap = (longint'(d[73:62]) + 1) << (int'(d[49:47]) + 2) << int'(d[83:80]);
    `CHK(cap, longint'(32112640))
    acc(1'b1, cdf_pkg::OFS_DESC3, 32'hFFFFFFFF, r);
    acc(1'b0, cdf_pkg::OFS_DESC3, 32'h0, r);
    `CHK(r, {cdf_pkg::VAL_STRUCTURE, cdf_pkg::VAL_SPEC, 2'h0, cdf_pkg::VAL_ACCESS_TIME,
             cdf_pkg::VAL_ACCESS_CLKS, cdf_pkg::VAL_XFER_SPEED})
    acc(1'b1, 8'h40, 32'h12345678, r);
    acc(1'b0, 8'h40, 32'h0, r);
    `CHK(r, 32'h0)
    cmd_chk(1'b1, 1'b0, 12'h200, 1'b1);
    cmd_chk(1'b1, 1'b0, 12'h100, 1'b0);
    cmd_chk(1'b1, 1'b0, 12'h400, 1'b0);
    cmd_chk(1'b1, 1'b0, 12'h1FF, 1'b0);
    for (int i = 0; i < 4; i++) begin
      prog(pv(1'b0, 1'b0, 1'b0, 2'(i), 2'(i % 2), 7'h00));
      `CHK(d[15:8], {1'b0, 3'h0, 2'(i), 2'(i % 2)})
    end
    prog(pv(1'b0, 1'b0, 1'b0, 2'h3, 2'h0, 7'h00) | 32'h0000_0008);
    `CHK(d[15], 1'b1)
    prog(pv(1'b0, 1'b0, 1'b1, 2'h2, 2'h1, 7'h00));
    `CHK(d[12], 1'b1)
    cmd_chk(1'b1, 1'b0, 12'h200, 1'b0);
    cmd_chk(1'b0, 1'b1, 12'h200, 1'b0);
    cmd_chk(1'b0, 1'b0, 12'h200, 1'b1);
    acc(1'b0, cdf_pkg::OFS_STATUS, 32'h0, r);
    `CHK(r[10:9], 2'h3)
    acc(1'b1, cdf_pkg::OFS_STATUS, 32'h00000400, r);
    prog(pv(1'b1, 1'b0, 1'b0, 2'h2, 2'h1, 7'h00));
    cmd_chk(1'b0, 1'b1, 12'h200, 1'b1);
    acc(1'b0, cdf_pkg::OFS_STATUS, 32'h0, r);
    `CHK(r[10:9], 2'h0)
    prog(pv(1'b0, 1'b0, 1'b0, 2'h2, 2'h1, 7'h00));
    `CHK(d[14], 1'b1)
    c = host.crc7(d[127:8]);
    acc(1'b0, cdf_pkg::OFS_STATUS, 32'h0, r);
    `CHK(r[6:0], c)
    prog(pv(1'b1, 1'b0, 1'b0, 2'h2, 2'h1, c));
    `CHK(d[7:0], {c, 1'b1})
    acc(1'b0, cdf_pkg::OFS_STATUS, 32'h0, r);
    `CHK(r[8], 1'b1)
    prog(pv(1'b1, 1'b1, 1'b0, 2'h2, 2'h1, c));
    prog(pv(1'b1, 1'b0, 1'b0, 2'h2, 2'h1, c));
    `CHK(d[14:12], 3'h6)
    cmd_chk(1'b1, 1'b0, 12'h200, 1'b0);
    cmd_chk(1'b0, 1'b1, 12'h200, 1'b0);
    report_and_stop();
  end
endmodule
